// *** hdl/charge_pkg.sv ***
// constants, state and target encodings for the charge sequencer
package charge_pkg;

    // ==============================
    // clock and time base
    localparam int CLK_HZ = 40_000_000;
    localparam int CLK_MHZ = CLK_HZ / 1_000_000;
    localparam int TICK_HZ = 8;
    localparam int TICK_CYCLES_DEF = CLK_HZ / TICK_HZ;
    localparam int TICK_W = 23;

    // ==============================
    // lockout deglitch, least time so rounded up
    localparam int DEGLITCH_NS = 10_000;
    localparam int DEGLITCH_CYCLES = (DEGLITCH_NS * CLK_MHZ + 999) / 1000;
    localparam int DGL_W = 10;
    localparam logic [DGL_W-1:0] DGL_LAST = DGL_W'(DEGLITCH_CYCLES - 1);

    // ==============================
    // charge timing, counted in ticks
    localparam int TMR_W = 18;
    localparam int SECS_PER_MIN = 60;
    localparam int FILTER_S = 4;
    localparam int PRECHARGE_LIMIT_MIN = 30;
    localparam int BLANK_TENTH_MIN = 43;
    localparam logic [TMR_W-1:0] FILTER_TICKS = TMR_W'(FILTER_S * TICK_HZ);
    localparam logic [TMR_W-1:0] PRECHARGE_TICKS = TMR_W'(PRECHARGE_LIMIT_MIN * SECS_PER_MIN * TICK_HZ);
    localparam logic [TMR_W-1:0] BLANK_TICKS = TMR_W'(BLANK_TENTH_MIN * SECS_PER_MIN * TICK_HZ / 10);
    localparam logic [TMR_W-1:0] TICKS_PER_MIN = TMR_W'(SECS_PER_MIN * TICK_HZ);
    localparam int FAST_MIN_W = 9;
    localparam logic [TMR_W-1:0] TMR_ZERO = 18'h00000;

    // ==============================
    // indicator blink taps on the free tick counter
    localparam int BLINK_W = 3;
    localparam int BLINK_4HZ_BIT = 0;
    localparam int BLINK_1HZ_BIT = 2;

    // ==============================
    // sequencer states, one-hot
    typedef enum logic [7:0] {
        ST_RESET     = 8'h01,
        ST_PRESENCE  = 8'h02,
        ST_PRECHARGE = 8'h04,
        ST_FAST      = 8'h08,
        ST_TOPOFF    = 8'h10,
        ST_DONE      = 8'h20,
        ST_FAULT     = 8'h40,
        ST_DISCHARGE = 8'h80
    } state_t;

    // ==============================
    // regulation target handed to the analog loop
    typedef enum logic [2:0] {
        TGT_OFF         = 3'h0,
        TGT_TOPOFF_LIN  = 3'h1,
        TGT_TOPOFF_COMP = 3'h2,
        TGT_FAST_LIN    = 3'h3,
        TGT_FAST_COMP   = 3'h4
    } target_t;

endpackage

// *** hdl/timer_if.sv ***
// control and status bundle between the sequencer and one tick timer
`timescale 1ns/1ps
interface timer_if;
    import charge_pkg::*;
    logic clear;
    logic tick;
    logic [TMR_W-1:0] limit;
    logic expired;
    modport ctrl (output clear, output tick, output limit, input expired);
    modport tmr (input clear, input tick, input limit, output expired);
endinterface

// *** hdl/tick_timer.sv ***
// tick counter with clear and terminal count, used for every charge timer
`timescale 1ns/1ps
module tick_timer
(
    input wire logic mclk_in,
    input wire logic rst_in,
    timer_if.tmr t
);
    import charge_pkg::*;

    logic [TMR_W-1:0] count_r;
    logic [TMR_W-1:0] count_nxt;
    logic at_limit;

    // ==============================
    // counting
    // saturates at the limit so a late read still sees expiry
    assign at_limit = (count_r >= t.limit);
    assign count_nxt = t.clear ? TMR_ZERO : ((t.tick && !at_limit) ? count_r + 1'b1 : count_r);
    // expiry comes from the count alone: the clear is built from expiry, so gating it would close a loop
    assign t.expired = at_limit;

    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
            count_r <= TMR_ZERO;
        else
            count_r <= count_nxt;
    end

endmodule

// *** hdl/charge_sequencer.sv ***
// charge-state sequencer for a series nickel-metal-hydride stack
//
// Behaviour
// - charge starts at power-up or on insertion
// - lockout inhibits charge, resets state, clears timers
// - lockout input deglitched over ten microseconds
// - lockout release moves reset into presence
// - presence to pre-charge on detect with good temperature
// - out-of-band temperature holds presence
// - four-second cell-voltage filter entering pre-charge
// - pre-charge selects reduced regulation target
// - pre-charge to fast charge above low-cell
// - pre-charge timeout or over-temperature gives fault
// - no-cell in pre-charge or fast returns presence
// - fast charge selects high regulation target
// - slope trip moves fast charge to top-off
// - slope ignored first 4.3 minutes
// - selectable fast timer expiry enters top-off
// - over-temperature in fast charge goes done
// - top-off restarts timer at half duration
// - top-off expiry or over-temperature goes done
// - done releases drive, result indicator steady
// - done waits for no-cell, then presence
// - fault releases drive, blinks, waits for removal
// - reverse current enters discharge, drive low
// - forward current leaves discharge to presence
// - charging indicator blinks 1 Hz while charging
// - fault blinks 4 Hz; idle indicators released
// - mode input picks linear or comparator targets
`timescale 1ns/1ps
module charge_sequencer
#(
    parameter int TICK_CYCLES = charge_pkg::TICK_CYCLES_DEF
)
(
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic supply_lockout_in,
    input wire logic below_cell_detect_in,
    input wire logic above_no_cell_in,
    input wire logic above_low_cell_in,
    input wire logic temp_in_band_in,
    input wire logic over_temperature_in,
    input wire logic temperature_slope_trip_in,
    input wire logic discharge_set_in,
    input wire logic discharge_reset_in,
    input wire logic comparator_mode_in,
    input wire logic [charge_pkg::FAST_MIN_W-1:0] fast_timeout_min_in,
    output logic charge_regulate_out,
    output charge_pkg::target_t target_sel_out,
    output logic charge_drive_out,
    output logic charge_drive_oe_out,
    output logic sense_enable_out,
    output logic charging_indicator_out,
    output logic charging_indicator_oe_out,
    output logic result_indicator_out,
    output logic result_indicator_oe_out,
    output charge_pkg::state_t state_out
);
    import charge_pkg::*;

    // ==============================
    // input registration
    // one stage only; the flags already arrive synchronous to the clock
    logic below_det_r;
    logic no_cell_r;
    logic low_cell_r;
    logic band_r;
    logic hot_r;
    logic slope_r;
    logic dchg_set_r;
    logic dchg_rst_r;
    logic comp_mode_r;
    logic lockout_raw_r;

    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            below_det_r <= 1'b0;
            no_cell_r <= 1'b1;
            low_cell_r <= 1'b0;
            band_r <= 1'b0;
            hot_r <= 1'b0;
            slope_r <= 1'b0;
            dchg_set_r <= 1'b0;
            dchg_rst_r <= 1'b0;
            comp_mode_r <= 1'b0;
            lockout_raw_r <= 1'b1;
        end
        else
        begin
            below_det_r <= below_cell_detect_in;
            no_cell_r <= above_no_cell_in;
            low_cell_r <= above_low_cell_in;
            band_r <= temp_in_band_in;
            hot_r <= over_temperature_in;
            slope_r <= temperature_slope_trip_in;
            dchg_set_r <= discharge_set_in;
            dchg_rst_r <= discharge_reset_in;
            comp_mode_r <= comparator_mode_in;
            lockout_raw_r <= supply_lockout_in;
        end
    end

    // ==============================
    // lockout deglitch
    // the decision flips only after the raw level has disagreed for the whole window
    // a pulse shorter than the window restarts the count and leaves the decision alone
    logic lockout_r;
    logic lockout_nxt;
    logic [DGL_W-1:0] dgl_cnt_r;
    logic [DGL_W-1:0] dgl_cnt_nxt;
    wire dgl_differs = (lockout_raw_r != lockout_r);
    wire dgl_done = (dgl_cnt_r == DGL_LAST);

    assign dgl_cnt_nxt = (!dgl_differs || dgl_done) ? '0 : dgl_cnt_r + 1'b1;
    assign lockout_nxt = (dgl_differs && dgl_done) ? lockout_raw_r : lockout_r;

    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            lockout_r <= 1'b1;
            dgl_cnt_r <= '0;
        end
        else
        begin
            lockout_r <= lockout_nxt;
            dgl_cnt_r <= dgl_cnt_nxt;
        end
    end

    // ==============================
    // time base
    // blink taps share the tick counter, so both patterns run off one divider
    logic [TICK_W-1:0] pre_cnt_r;
    logic [BLINK_W-1:0] blink_cnt_r;
    wire tick = (pre_cnt_r == TICK_W'(TICK_CYCLES - 1));

    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            pre_cnt_r <= '0;
            blink_cnt_r <= '0;
        end
        else
        begin
            pre_cnt_r <= tick ? '0 : pre_cnt_r + 1'b1;
            blink_cnt_r <= tick ? blink_cnt_r + 1'b1 : blink_cnt_r;
        end
    end

    wire blink_1hz = blink_cnt_r[BLINK_1HZ_BIT];
    wire blink_4hz = blink_cnt_r[BLINK_4HZ_BIT];

    // ==============================
    // timers: charge duration, insertion filter, slope blanking
    state_t state_r;
    state_t state_nxt;
    timer_if chg_t ();
    timer_if flt_t ();
    timer_if blk_t ();

    tick_timer u_chg_timer (.mclk_in(mclk_in), .rst_in(rst_in), .t(chg_t.tmr));
    tick_timer u_flt_timer (.mclk_in(mclk_in), .rst_in(rst_in), .t(flt_t.tmr));
    tick_timer u_blk_timer (.mclk_in(mclk_in), .rst_in(rst_in), .t(blk_t.tmr));

    // every state change restarts all timers, which also gives top-off a fresh count
    wire state_change = (state_nxt != state_r);
    wire timers_clear = lockout_r || state_change;
    wire [TMR_W-1:0] fast_ticks = TMR_W'(fast_timeout_min_in) * TICKS_PER_MIN;
    wire [TMR_W-1:0] topoff_ticks = fast_ticks >> 1;

    assign chg_t.clear = timers_clear;
    assign chg_t.tick = tick;
    assign chg_t.limit = (state_r == ST_PRECHARGE) ? PRECHARGE_TICKS
                       : (state_r == ST_TOPOFF) ? topoff_ticks : fast_ticks;
    assign flt_t.clear = timers_clear;
    assign flt_t.tick = tick;
    assign flt_t.limit = FILTER_TICKS;
    assign blk_t.clear = timers_clear;
    assign blk_t.tick = tick;
    assign blk_t.limit = BLANK_TICKS;

    wire chg_expired = chg_t.expired;
    wire filter_done = flt_t.expired;
    wire blank_done = blk_t.expired;

    // ==============================
    // state decisions
    // voltage decisions in pre-charge wait for the insertion filter; thermal faults do not
    wire vbatt_valid = filter_done;
    wire go_discharge = dchg_set_r && (state_r != ST_RESET) && (state_r != ST_DISCHARGE);

    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            ST_RESET:
                if (!lockout_r)
                    state_nxt = ST_PRESENCE;
            ST_PRESENCE:
                if (below_det_r && band_r)
                    state_nxt = ST_PRECHARGE;
            ST_PRECHARGE:
                if (hot_r || chg_expired)
                    state_nxt = ST_FAULT;
                else if (vbatt_valid && no_cell_r)
                    state_nxt = ST_PRESENCE;
                else if (vbatt_valid && low_cell_r)
                    state_nxt = ST_FAST;
            ST_FAST:
                if (no_cell_r)
                    state_nxt = ST_PRESENCE;
                else if (hot_r)
                    state_nxt = ST_DONE;
                else if (slope_r && blank_done)
                    state_nxt = ST_TOPOFF;
                else if (chg_expired)
                    state_nxt = ST_TOPOFF;
            // removal is not acted on in top-off; the pack is released from done
            ST_TOPOFF:
                if (hot_r || chg_expired)
                    state_nxt = ST_DONE;
            ST_DONE:
                if (no_cell_r)
                    state_nxt = ST_PRESENCE;
            ST_FAULT:
                if (no_cell_r)
                    state_nxt = ST_PRESENCE;
            ST_DISCHARGE:
                if (dchg_rst_r)
                    state_nxt = ST_PRESENCE;
            default:
                state_nxt = ST_RESET;
        endcase
        // discharge (except from reset or discharge), then lockout, override every case; lockout last so it wins
        if (go_discharge)
            state_nxt = ST_DISCHARGE;
        if (lockout_r)
            state_nxt = ST_RESET;
    end

    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
            state_r <= ST_RESET;
        else
            state_r <= state_nxt;
    end

    // ==============================
    // output decode
    wire charging = (state_r == ST_PRECHARGE) || (state_r == ST_FAST) || (state_r == ST_TOPOFF);
    wire reduced = (state_r == ST_PRECHARGE) || (state_r == ST_TOPOFF);
    target_t target_nxt;

    assign target_nxt = !charging ? TGT_OFF
                      : reduced ? (comp_mode_r ? TGT_TOPOFF_COMP : TGT_TOPOFF_LIN)
                      : (comp_mode_r ? TGT_FAST_COMP : TGT_FAST_LIN);

    // discharge hands the pass element to the load: drive low, sensing and indicators off
    wire in_discharge = (state_r == ST_DISCHARGE);
    wire in_done = (state_r == ST_DONE);
    wire in_fault = (state_r == ST_FAULT);

    // indicators only ever pull low; the enables carry the pattern
    wire chg_led_on = charging && blink_1hz;
    wire res_led_on = in_done || (in_fault && blink_4hz);

    // state_out is a registered copy so it lines up with the other outputs

    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            charge_regulate_out <= 1'b0;
            target_sel_out <= TGT_OFF;
            charge_drive_oe_out <= 1'b0;
            sense_enable_out <= 1'b1;
            charging_indicator_oe_out <= 1'b0;
            result_indicator_oe_out <= 1'b0;
            state_out <= ST_RESET;
        end
        else
        begin
            charge_regulate_out <= charging && !lockout_r;
            target_sel_out <= target_nxt;
            charge_drive_oe_out <= in_discharge;
            sense_enable_out <= !in_discharge;
            charging_indicator_oe_out <= chg_led_on;
            result_indicator_oe_out <= res_led_on;
            state_out <= state_r;
        end
    end

    assign charge_drive_out = 1'b0;
    assign charging_indicator_out = 1'b0;
    assign result_indicator_out = 1'b0;

endmodule

// *** dv/charge_props.sv ***
// port assertions for the charge sequencer
`timescale 1ns/1ps
module charge_props
    import charge_pkg::*;
#(
    parameter int TICK_CYCLES = 4
)
(
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic supply_lockout_in,
    input wire logic comparator_mode_in,
    input wire logic charge_regulate_out,
    input wire target_t target_sel_out,
    input wire logic charge_drive_oe_out,
    input wire logic sense_enable_out,
    input wire logic charging_indicator_oe_out,
    input wire logic result_indicator_oe_out,
    input wire state_t state_out
);
    // ==========
    // run lengths: lockout high, lockout low, fault blink phase
    logic [9:0] hi_r;
    logic [9:0] lo_r;
    logic [9:0] rb_r;
    always_ff @(posedge mclk_in)
    begin
        hi_r <= (rst_in || !supply_lockout_in) ? 10'h000 : hi_r + 10'(!hi_r[9]);
        lo_r <= (rst_in || supply_lockout_in) ? 10'h000 : lo_r + 10'(!lo_r[9]);
        rb_r <= (rst_in || state_out != ST_FAULT || $changed(result_indicator_oe_out)) ? 10'h000 : rb_r + 10'(!rb_r[9]);
    end
    default clocking @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    sequence dis_leave;
        state_out == ST_DISCHARGE ##1 state_out != ST_DISCHARGE;
    endsequence
    // ==========
    // checks
    lockout_reset_a: assert property (hi_r >= 10'd410 |-> state_out == ST_RESET && !charge_regulate_out)
        else $error("long lockout did not reset");
    release_presence_a: assert property (lo_r == 10'd420 |-> state_out != ST_RESET)
        else $error("still in reset after release");
    reduced_target_a: assert property (state_out inside {ST_PRECHARGE, ST_TOPOFF} |->
        target_sel_out == (comparator_mode_in ? TGT_TOPOFF_COMP : TGT_TOPOFF_LIN))
        else $error("wrong reduced target");
    fast_target_a: assert property (state_out == ST_FAST |->
        target_sel_out == (comparator_mode_in ? TGT_FAST_COMP : TGT_FAST_LIN) && !result_indicator_oe_out)
        else $error("wrong fast target");
    done_entry_a: assert property ($rose(state_out == ST_DONE) |-> $past(state_out) inside {ST_FAST, ST_TOPOFF})
        else $error("done entered from wrong state");
    done_steady_a: assert property (state_out == ST_DONE |-> result_indicator_oe_out && !charge_drive_oe_out)
        else $error("done outputs wrong");
    fault_release_a: assert property (state_out == ST_FAULT |->
        !charge_drive_oe_out && !charging_indicator_oe_out && !charge_regulate_out)
        else $error("fault outputs wrong");
    fault_blink_a: assert property (rb_r <= 10'(TICK_CYCLES + 1))
        else $error("fault blink too slow");
    discharge_out_a: assert property (state_out == ST_DISCHARGE |-> charge_drive_oe_out && !sense_enable_out
        && !charging_indicator_oe_out && !result_indicator_oe_out)
        else $error("discharge outputs wrong");
    discharge_exit_a: assert property (dis_leave |-> state_out inside {ST_PRESENCE, ST_RESET})
        else $error("discharge left to wrong state");
endmodule

bind charge_sequencer charge_props #(.TICK_CYCLES(TICK_CYCLES)) charge_props_inst (.mclk_in, .rst_in,
    .supply_lockout_in, .comparator_mode_in, .charge_regulate_out, .target_sel_out, .charge_drive_oe_out,
    .sense_enable_out, .charging_indicator_oe_out, .result_indicator_oe_out, .state_out);

// *** dv/cell_pack_model.sv ***
// cell pack, thermistor and load seen as threshold flags
`timescale 1ns/1ps
module cell_pack_model
(
    input wire logic present_in,
    input wire logic load_in,
    input wire logic slope_in,
    input wire integer cell_mv_in,
    input wire integer temp_c_in,
    output logic below_det_out,
    output logic no_cell_out,
    output logic low_cell_out,
    output logic band_out,
    output logic hot_out,
    output logic slope_out,
    output logic dis_set_out,
    output logic dis_rst_out
);
    // an empty holder floats up to the open charger voltage
    int mv;
    assign mv = present_in ? cell_mv_in : 2000;
    assign below_det_out = mv < 1550;
    assign no_cell_out = mv > 1650;
    assign low_cell_out = mv > 1000;
    assign band_out = temp_c_in > 0 && temp_c_in < 45;
    assign hot_out = temp_c_in >= 50;
    assign slope_out = slope_in;
    assign dis_set_out = present_in && load_in;
    assign dis_rst_out = !load_in;
endmodule

// *** dv/testbench.sv ***
// self-checking bench for the charge sequencer
`timescale 1ns/1ps
module testbench;
    import charge_pkg::*;
    logic mclk_in, rst_in, supply_lockout_in, comparator_mode_in, present, load, slope;
    int cell_mv, temp_c, c_on, r_on;
    int error_cnt = 0;
    int n_compared = 0;
    logic below_cell_detect_in, above_no_cell_in, above_low_cell_in, temp_in_band_in, over_temperature_in;
    logic temperature_slope_trip_in, discharge_set_in, discharge_reset_in, charge_regulate_out, charge_drive_out;
    logic charge_drive_oe_out, sense_enable_out, charging_indicator_out, charging_indicator_oe_out;
    logic result_indicator_out, result_indicator_oe_out;
    target_t target_sel_out;
    state_t state_out;
    logic [FAST_MIN_W-1:0] fast_min;
    charge_sequencer #(.TICK_CYCLES(2)) charge_sequencer_inst (.mclk_in, .rst_in, .supply_lockout_in,
        .below_cell_detect_in, .above_no_cell_in, .above_low_cell_in, .temp_in_band_in, .over_temperature_in,
        .temperature_slope_trip_in, .discharge_set_in, .discharge_reset_in, .comparator_mode_in,
        .fast_timeout_min_in(fast_min), .charge_regulate_out, .target_sel_out, .charge_drive_out,
        .charge_drive_oe_out, .sense_enable_out, .charging_indicator_out, .charging_indicator_oe_out,
        .result_indicator_out, .result_indicator_oe_out, .state_out);
    cell_pack_model cell_pack_model_inst (.present_in(present), .load_in(load), .slope_in(slope),
        .cell_mv_in(cell_mv), .temp_c_in(temp_c), .below_det_out(below_cell_detect_in),
        .no_cell_out(above_no_cell_in), .low_cell_out(above_low_cell_in), .band_out(temp_in_band_in),
        .hot_out(over_temperature_in), .slope_out(temperature_slope_trip_in),
        .dis_set_out(discharge_set_in), .dis_rst_out(discharge_reset_in));
    initial
    begin
        mclk_in = 1'b0;
        forever #12.5 mclk_in = ~mclk_in;
    end
    // ==========
    // tasks
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk_in);
    endtask
    task automatic bad(input string m);
        error_cnt++;
        $display("BAD t=%0t %s", $time, m);
    endtask
    task automatic chk_b(input logic g, input logic e);
        n_compared++;
        if (g !== e)
            bad("flag mismatch");
    endtask
    task automatic chk_t(input target_t e);
        n_compared++;
        if (target_sel_out !== e)
            bad("target mismatch");
    endtask
    task automatic chk_s(input state_t e);
        n_compared++;
        if (state_out !== e)
            bad("state mismatch");
    endtask
    // bounded wait; a miss ends the run
    task automatic wait_st(input state_t e);
        int i;
        i = 0;
        while (state_out !== e && i < 40000)
        begin
            cyc(1);
            i++;
        end
        chk_s(e);
        if (state_out !== e)
            conclude();
    endtask
    task automatic watch(input int n);
        c_on = 0;
        r_on = 0;
        repeat (n)
        begin
            cyc(1);
            c_on += int'(charging_indicator_oe_out === 1'b1);
            r_on += int'(result_indicator_oe_out === 1'b1);
        end
    endtask
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // ==========
    // scenarios
    initial
    begin
        rst_in = 1'b1;
        supply_lockout_in = 1'b1;
        comparator_mode_in = 1'b0;
        present = 1'b0;
        load = 1'b0;
        slope = 1'b0;
        cell_mv = 800;
        temp_c = 25;
        fast_min = 9'h03c;
        cyc(5);
        rst_in = 1'b0;
        cyc(50);
        supply_lockout_in = 1'b0;
        wait_st(ST_PRESENCE);
        temp_c = -5;
        present = 1'b1;
        cyc(60);
        chk_s(ST_PRESENCE);
        temp_c = 25;
        wait_st(ST_PRECHARGE);
        chk_t(TGT_TOPOFF_LIN);
        cell_mv = 1200;
        cyc(40);
        chk_s(ST_PRECHARGE);
        wait_st(ST_FAST);
        chk_t(TGT_FAST_LIN);
        chk_b(charge_regulate_out, 1'b1);
        watch(64);
        chk_b(c_on == 32 && r_on == 0, 1'b1);
        chk_b(charging_indicator_out, 1'b0);
        slope = 1'b1;
        cyc(3000);
        chk_s(ST_FAST);
        wait_st(ST_TOPOFF);
        slope = 1'b0;
        cyc(26000);
        chk_s(ST_TOPOFF);
        wait_st(ST_DONE);
        watch(64);
        chk_b(r_on == 64 && c_on == 0 && !charge_drive_oe_out, 1'b1);
        chk_b(charge_regulate_out || result_indicator_out, 1'b0);
        present = 1'b0;
        wait_st(ST_PRESENCE);
        chk_b(charging_indicator_oe_out || result_indicator_oe_out, 1'b0);
        $display("test linear cycle finished");
        comparator_mode_in = 1'b1;
        fast_min = 9'h01e;
        cell_mv = 800;
        present = 1'b1;
        wait_st(ST_PRECHARGE);
        chk_t(TGT_TOPOFF_COMP);
        temp_c = 55;
        wait_st(ST_FAULT);
        watch(64);
        chk_b(r_on == 32 && c_on == 0 && !charge_drive_oe_out, 1'b1);
        present = 1'b0;
        temp_c = 25;
        wait_st(ST_PRESENCE);
        $display("test fault finished");
        present = 1'b1;
        wait_st(ST_PRECHARGE);
        cell_mv = 1200;
        wait_st(ST_FAST);
        chk_t(TGT_FAST_COMP);
        supply_lockout_in = 1'b1;
        cyc(200);
        supply_lockout_in = 1'b0;
        cyc(20);
        chk_s(ST_FAST);
        present = 1'b0;
        wait_st(ST_PRESENCE);
        present = 1'b1;
        load = 1'b1;
        wait_st(ST_DISCHARGE);
        chk_b(charge_drive_oe_out && !sense_enable_out && !result_indicator_oe_out, 1'b1);
        chk_b(charge_drive_out, 1'b0);
        load = 1'b0;
        wait_st(ST_PRESENCE);
        wait_st(ST_FAST);
        cyc(26000);
        chk_s(ST_FAST);
        wait_st(ST_TOPOFF);
        supply_lockout_in = 1'b1;
        cyc(420);
        chk_s(ST_RESET);
        chk_b(charge_regulate_out, 1'b0);
        $display("test removal, discharge and lockout finished");
        conclude();
    end
endmodule
